// >>> logic/aad_decoder.sv
// Address abort decoder: classifies each core access against the memory map
// Assumes one access per cycle from the core, held with its address while valid
`timescale 1ns/1ps
module aad_decoder #(
    parameter int FLASH_KB = 512,
    parameter int SRAM_KB = 32,
    parameter logic EXT_MEM_PRESENT = 1'b0,
    parameter logic [127:0] PB_SLOTS = aad_pkg::AAD_PB_SLOTS_DEF,
    parameter logic [127:0] SB_SLOTS = aad_pkg::AAD_SB_SLOTS_DEF
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic req_valid,
    input wire logic [31:0] req_addr,
    input wire logic req_fetch,
    output logic fwd_valid,
    output logic [31:0] fwd_addr,
    output logic resp_err,
    output logic resp_prefetch_abort,
    output logic resp_data_abort,
    input wire logic pipe_advance,
    input wire logic pipe_flush,
    input wire logic exec_fire,
    output logic prefetch_abort_take,
    output logic [31:0] last_abort_addr_q,
    output logic last_abort_fetch_q
);
    import aad_pkg::*;

    // --------------------------------------------------------
    // Variant checks
    // --------------------------------------------------------
    // Only the documented variants have gap bounds
    if (FLASH_KB != 32 && FLASH_KB != 64 && FLASH_KB != 512) begin
        $error("FLASH_KB must be 32, 64 or 512");
    end
    if (SRAM_KB != 8 && SRAM_KB != 16 && SRAM_KB != 32) begin
        $error("SRAM_KB must be 8, 16 or 32");
    end

    // Slot occupancy test, used for both peripheral spaces
    function automatic logic slot_present(input logic [127:0] map, input logic [31:0] addr);
        logic [AAD_SLOT_BITS-1:0] idx;
        idx = addr[AAD_SLOT_LSB +: AAD_SLOT_BITS];
        return map[idx];
    endfunction

    // Inclusive range test
    function automatic logic in_range(input logic [31:0] addr, input logic [31:0] lo, input logic [31:0] hi);
        return (addr >= lo) && (addr <= hi);
    endfunction

    // --------------------------------------------------------
    // Gap bounds picked by the variant
    // --------------------------------------------------------
    // Flash gap start, one bound per flash size
    localparam logic [31:0] FLASH_GAP_LO = (FLASH_KB == 32) ? AAD_FLASH_GAP_32K :
        (FLASH_KB == 64) ? AAD_FLASH_GAP_64K : AAD_FLASH_GAP_512K;
    // Last SRAM byte, the gap begins just above it
    localparam logic [31:0] SRAM_END = (SRAM_KB == 8) ? AAD_SRAM_END_8K :
        (SRAM_KB == 16) ? AAD_SRAM_END_16K : AAD_SRAM_END_32K;
    localparam logic [31:0] SRAM_GAP_LO = SRAM_END + 32'h0000_0001;
    // The largest SRAM variant has a lower gap top than the others
    localparam logic [31:0] SRAM_GAP_HI = (SRAM_KB == 32) ? AAD_SRAM_GAP_TOP_32K : AAD_SRAM_GAP_TOP_STD;
    // Only the 512 kB flash part carries the optional peripheral slot
    localparam logic [127:0] PB_MAP = (FLASH_KB == 512) ? PB_SLOTS : (PB_SLOTS & ~AAD_PB_SLOT_OPT);

    // --------------------------------------------------------
    // Region decode
    // --------------------------------------------------------
    wire logic hit_flash_gap;
    wire logic hit_sram_gap;
    wire logic hit_ext;
    wire logic hit_pb;
    wire logic hit_sb;
    wire logic hit_reserved;
    wire logic hit_empty_slot;
    wire logic hit_periph;
    wire logic bad_area;
    wire logic abort_any;

    // Gap after flash up to the top of the reserved space
    assign hit_flash_gap = in_range(req_addr, FLASH_GAP_LO, AAD_FLASH_GAP_TOP);
    // Gap after SRAM, bounded by the variant's top
    assign hit_sram_gap = in_range(req_addr, SRAM_GAP_LO, SRAM_GAP_HI);
    assign hit_ext = in_range(req_addr, AAD_EXT_BASE, AAD_EXT_TOP);
    assign hit_pb = in_range(req_addr, AAD_PB_BASE, AAD_PB_TOP);
    assign hit_sb = in_range(req_addr, AAD_SB_BASE, AAD_SB_TOP);
    // Unmapped external window and the space between the two peripheral areas
    assign hit_reserved = (hit_ext && !EXT_MEM_PRESENT) ||
        in_range(req_addr, AAD_PB_TOP + 32'h0000_0001, AAD_SB_BASE - 32'h0000_0001);
    // Slots without a peripheral on either bus
    assign hit_empty_slot = (hit_pb && !slot_present(PB_MAP, req_addr)) ||
        (hit_sb && !slot_present(SB_SLOTS, req_addr));
    assign hit_periph = hit_pb || hit_sb;

    // Areas that abort every access, data and fetch alike
    assign bad_area = hit_flash_gap || hit_sram_gap || hit_reserved || hit_empty_slot;
    // Fetches from any peripheral slot abort, present or not
    assign abort_any = bad_area || (req_fetch && hit_periph);

    // --------------------------------------------------------
    // Response and forwarding
    // --------------------------------------------------------
    // Error answered in the request cycle; the access goes nowhere
    assign resp_err = req_valid && abort_any;
    assign resp_prefetch_abort = resp_err && req_fetch;
    assign resp_data_abort = resp_err && !req_fetch;
    // Data accesses to undefined offsets in a present slot pass on; the slot decodes only its own bits
    assign fwd_valid = req_valid && !abort_any;
    assign fwd_addr = req_addr;

    // --------------------------------------------------------
    // Last abort capture
    // --------------------------------------------------------
    // Holds the address and kind of the most recent abort
    always_ff @(posedge clock) begin
        if (!rstn) begin
            last_abort_addr_q <= 32'h0000_0000;
            last_abort_fetch_q <= 1'b0;
        end else if (resp_err) begin
            last_abort_addr_q <= req_addr;
            last_abort_fetch_q <= req_fetch;
        end
    end

    // --------------------------------------------------------
    // Prefetch flag tracking
    // --------------------------------------------------------
    // A flagged fetch enters the pipeline instead of aborting at once
    aad_flag_pipe #(
        .STAGES(AAD_PIPE_STAGES)
    ) u_flag_pipe (
        .clock(clock),
        .rstn(rstn),
        .fetch_flag(resp_prefetch_abort),
        .advance(pipe_advance),
        .flush(pipe_flush),
        .exec_fire(exec_fire),
        .prefetch_abort_take(prefetch_abort_take)
    );
endmodule

// >>> logic/aad_pkg.sv
// Constants of the address abort decoder: region bounds, slot layout, reset values
// Assumes a 32-bit byte address from the processor core and one core clock
// Behaviour
// - 32 kB flash: abort every access from 0x0000_8000 through 0x3fff_ffff.
// - 64 kB flash: abort every access from 0x0001_0000 up to the gap top.
// - 512 kB flash: abort every access from 0x0008_0000 up to the gap top.
// - 8 kB SRAM: abort the gap above SRAM, bounds 0x4000_1fff and 0x7fff_dfff.
// - 16 kB SRAM: abort the gap above SRAM from bound 0x4000_3fff upward.
// - 32 kB SRAM: abort the gap between 0x4000_7fff and 0x7fff_d000.
// - Abort accesses into reserved parts of system and peripheral bus spaces.
// - Abort accesses to peripheral slots that have no peripheral assigned.
// - Aborts apply to data and fetches, reported as data or prefetch abort.
// - Any instruction fetch from peripheral space gets a prefetch abort.
// - Data access to an undefined offset in a present slot completes normally.
// - Peripherals decode only the bits they need; undefined offsets may alias.
// - Prefetch abort flag rides with the instruction, taken only on execution.
// - Each peripheral space is 2 MB of 128 slots of 16 kB each.
package aad_pkg;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [31:0] AAD_FLASH_GAP_32K = 32'h0000_8000;
    localparam logic [31:0] AAD_FLASH_GAP_64K = 32'h0001_0000;
    localparam logic [31:0] AAD_FLASH_GAP_512K = 32'h0008_0000;
    localparam logic [31:0] AAD_FLASH_GAP_TOP = 32'h3fff_ffff;
    localparam logic [31:0] AAD_SRAM_END_8K = 32'h4000_1fff;
    localparam logic [31:0] AAD_SRAM_END_16K = 32'h4000_3fff;
    localparam logic [31:0] AAD_SRAM_END_32K = 32'h4000_7fff;
    localparam logic [31:0] AAD_SRAM_GAP_TOP_STD = 32'h7fff_dfff;
    localparam logic [31:0] AAD_SRAM_GAP_TOP_32K = 32'h7fff_d000;
    localparam logic [31:0] AAD_EXT_BASE = 32'h8000_0000;
    localparam logic [31:0] AAD_EXT_TOP = 32'hdfff_ffff;
    localparam logic [31:0] AAD_PB_BASE = 32'he000_0000;
    localparam logic [31:0] AAD_PB_TOP = 32'he01f_ffff;
    localparam logic [31:0] AAD_SB_BASE = 32'hffe0_0000;
    localparam logic [31:0] AAD_SB_TOP = 32'hffff_ffff;

    // ------------------------------------------------------------
    // Slot layout
    // ------------------------------------------------------------
    localparam int AAD_SLOT_LSB = 14;
    localparam int AAD_SLOT_BITS = 7;
    localparam int AAD_SLOT_COUNT = 128;

    // Default slot occupancy of the peripheral bus, one bit per slot
    localparam logic [127:0] AAD_PB_SLOTS_DEF = 128'h8000_0000_0000_0000_0000_0000_0d80_2fbf;
    // Slot 24 holds the second converter on 512 kB flash variants only
    localparam logic [127:0] AAD_PB_SLOT_OPT = 128'h0000_0000_0000_0000_0000_0000_0100_0000;
    localparam logic [127:0] AAD_SB_SLOTS_DEF = 128'h8000_0000_0000_0000_0000_0000_0000_0000;

    // ------------------------------------------------------------
    // Pipeline tracking
    // ------------------------------------------------------------
    localparam int AAD_PIPE_STAGES = 3;
    localparam logic AAD_FLAG_RESET = 1'b0;

endpackage

// >>> logic/aad_flag_pipe.sv
// Prefetch abort flag carried in step with the core's instruction pipeline
// Assumes the core gives advance, flush and execute strobes on the same clock
`timescale 1ns/1ps
module aad_flag_pipe #(
    parameter int STAGES = aad_pkg::AAD_PIPE_STAGES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic fetch_flag,
    input wire logic advance,
    input wire logic flush,
    input wire logic exec_fire,
    output logic prefetch_abort_take
);
    import aad_pkg::*;

    // Elaboration check: the shift needs a fetch stage and an execute stage
    if (STAGES < 2) begin
        $error("aad_flag_pipe needs at least two stages");
    end

    logic [STAGES-1:0] flag_q;
    logic [STAGES-1:0] flag_d;
    logic take_q;
    logic take_d;

    // --------------------------------------------------------
    // Flag shift and execute check
    // --------------------------------------------------------
    // Flush drops every flag so a discarded prefetch never aborts
    assign flag_d = flush ? '0 : (advance ? {flag_q[STAGES-2:0], fetch_flag} : flag_q);
    assign take_d = exec_fire && flag_q[STAGES-1] && !flush;

    // Stage flags and the abort strobe
    always_ff @(posedge clock) begin
        if (!rstn) begin
            flag_q <= {STAGES{AAD_FLAG_RESET}};
            take_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            take_q <= take_d;
        end
    end

    assign prefetch_abort_take = take_q;
endmodule

// >>> test/aad_decoder_props.sv
// Port checker for the address abort decoder
// Assumes it is bound to every aad_decoder instance with that instance's sizes
`timescale 1ns/1ps
module aad_decoder_props import aad_pkg::*; #(
    parameter int FLASH_KB = 512,
    parameter int SRAM_KB = 32
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic req_valid,
    input wire logic [31:0] req_addr,
    input wire logic req_fetch,
    input wire logic fwd_valid,
    input wire logic [31:0] fwd_addr,
    input wire logic resp_err,
    input wire logic resp_prefetch_abort,
    input wire logic resp_data_abort,
    input wire logic pipe_flush,
    input wire logic prefetch_abort_take,
    input wire logic [31:0] last_abort_addr_q,
    input wire logic last_abort_fetch_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // First aborted address above flash for this size
    wire logic [31:0] gap_lo = FLASH_KB == 32 ? AAD_FLASH_GAP_32K : FLASH_KB == 64 ? AAD_FLASH_GAP_64K : AAD_FLASH_GAP_512K;
    wire logic periph_area = req_addr[31:21] == 11'h700 || req_addr[31:21] == 11'h7ff;
    // First and last aborted address above SRAM for this size
    wire logic [31:0] sram_lo = SRAM_KB == 8 ? 32'h4000_2000 : SRAM_KB == 16 ? 32'h4000_4000 : 32'h4000_8000;
    wire logic [31:0] sram_hi = SRAM_KB == 32 ? AAD_SRAM_GAP_TOP_32K : AAD_SRAM_GAP_TOP_STD;
    property p_sram_gap; req_valid && req_addr >= sram_lo && req_addr <= sram_hi |-> resp_err; endproperty
    property p_one_answer; req_valid |-> fwd_valid != resp_err; endproperty
    property p_fwd_addr; fwd_valid |-> fwd_addr == req_addr; endproperty
    property p_kind; resp_prefetch_abort == (resp_err && req_fetch) && resp_data_abort == (resp_err && !req_fetch); endproperty
    property p_flash_gap; req_valid && req_addr >= gap_lo && req_addr <= 32'h3fff_ffff |-> resp_err; endproperty
    property p_periph_fetch; req_valid && req_fetch && periph_area |-> resp_err; endproperty
    property p_reserved; req_valid && req_addr >= 32'he020_0000 && req_addr <= 32'hffdf_ffff |-> resp_err; endproperty
    property p_record; req_valid && resp_err |=> last_abort_addr_q == $past(req_addr) && last_abort_fetch_q == $past(req_fetch); endproperty
    property p_flush_blocks; pipe_flush |=> !prefetch_abort_take; endproperty
    a_one_answer: assert property (p_one_answer) else $error("access both forwarded and refused");
    a_fwd_addr: assert property (p_fwd_addr) else $error("forwarded address differs");
    a_kind: assert property (p_kind) else $error("abort kind wrong");
    a_flash_gap: assert property (p_flash_gap) else $error("flash gap not aborted");
    a_periph_fetch: assert property (p_periph_fetch) else $error("peripheral fetch not aborted");
    a_sram_gap: assert property (p_sram_gap) else $error("SRAM gap not aborted");
    a_reserved: assert property (p_reserved) else $error("reserved area not aborted");
    a_record: assert property (p_record) else $error("abort record wrong");
    a_flush_blocks: assert property (p_flush_blocks) else $error("abort taken after flush");
    c_data_abort: cover property (req_valid && resp_data_abort);
    c_fetch_abort: cover property (req_valid && resp_prefetch_abort);
    c_take: cover property (prefetch_abort_take);
endmodule
bind aad_decoder aad_decoder_props #(.FLASH_KB(FLASH_KB), .SRAM_KB(SRAM_KB)) u_props (.clock(clock), .rstn(rstn),
    .req_valid(req_valid), .req_addr(req_addr), .req_fetch(req_fetch), .fwd_valid(fwd_valid), .fwd_addr(fwd_addr),
    .resp_err(resp_err), .resp_prefetch_abort(resp_prefetch_abort), .resp_data_abort(resp_data_abort),
    .pipe_flush(pipe_flush), .prefetch_abort_take(prefetch_abort_take), .last_abort_addr_q(last_abort_addr_q),
    .last_abort_fetch_q(last_abort_fetch_q));

// >>> test/aad_core_model.sv
// Processor core stand-in: issues accesses and steps its pipeline strobes
// Assumes the bench calls cyc once per clock; values change just after a rising edge
`timescale 1ns/1ps
module aad_core_model (
    input wire logic clock,
    output logic req_valid,
    output logic [31:0] req_addr,
    output logic req_fetch,
    output logic pipe_advance,
    output logic pipe_flush,
    output logic exec_fire
);
    initial begin
        {req_valid, req_addr, req_fetch, pipe_advance, pipe_flush, exec_fire} = '0;
    end
    // One core cycle; an idle bus shows the inverted address, not a stale one
    task automatic cyc(input logic v, input logic [31:0] a, input logic f, input logic adv, input logic fl,
                       input logic ex);
        @(posedge clock);
        req_valid <= v;
        req_addr <= v ? a : ~req_addr;
        req_fetch <= f;
        pipe_advance <= adv;
        pipe_flush <= fl;
        exec_fire <= ex;
    endtask
endmodule

// >>> test/address_abort_decoder_bench.sv
// Self-checking bench for the address abort decoder, large and small variants
// Assumes the core model drives all requests and pipeline strobes
`timescale 1ns/1ps
module address_abort_decoder_bench;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic req_valid, req_fetch, pipe_advance, pipe_flush, exec_fire, fwd_valid, resp_err;
    logic resp_prefetch_abort, resp_data_abort, prefetch_abort_take, last_abort_fetch_q, small_err, mid_err;
    logic [31:0] req_addr, fwd_addr, last_abort_addr_q;
    int errors = 0;
    int num_checks = 0;
    always #5 clock = ~clock;
    aad_core_model u_core (.clock(clock), .req_valid(req_valid), .req_addr(req_addr), .req_fetch(req_fetch),
        .pipe_advance(pipe_advance), .pipe_flush(pipe_flush), .exec_fire(exec_fire));
    aad_decoder u_dut (.clock(clock), .rstn(rstn), .req_valid(req_valid), .req_addr(req_addr), .req_fetch(req_fetch),
        .fwd_valid(fwd_valid), .fwd_addr(fwd_addr), .resp_err(resp_err), .resp_prefetch_abort(resp_prefetch_abort),
        .resp_data_abort(resp_data_abort), .pipe_advance(pipe_advance), .pipe_flush(pipe_flush),
        .exec_fire(exec_fire), .prefetch_abort_take(prefetch_abort_take), .last_abort_addr_q(last_abort_addr_q),
        .last_abort_fetch_q(last_abort_fetch_q));
    aad_decoder #(.FLASH_KB(32), .SRAM_KB(8)) u_dut_small (.clock(clock), .rstn(rstn), .req_valid(req_valid),
        .req_addr(req_addr), .req_fetch(req_fetch), .fwd_valid(), .fwd_addr(), .resp_err(small_err),
        .resp_prefetch_abort(), .resp_data_abort(), .pipe_advance(pipe_advance), .pipe_flush(pipe_flush),
        .exec_fire(exec_fire), .prefetch_abort_take(), .last_abort_addr_q(), .last_abort_fetch_q());
    // Middle variant with the external window mapped
    aad_decoder #(.FLASH_KB(64), .SRAM_KB(16), .EXT_MEM_PRESENT(1'b1)) u_dut_mid (.clock(clock), .rstn(rstn),
        .req_valid(req_valid), .req_addr(req_addr), .req_fetch(req_fetch), .fwd_valid(), .fwd_addr(),
        .resp_err(mid_err), .resp_prefetch_abort(), .resp_data_abort(), .pipe_advance(pipe_advance),
        .pipe_flush(pipe_flush), .exec_fire(exec_fire), .prefetch_abort_take(), .last_abort_addr_q(),
        .last_abort_fetch_q());
    // Compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Back-to-back accesses; row is {addr, fetch, large aborts, small aborts}
    task automatic run_regions();
        logic [34:0] tab [20] = '{
            {32'h0000_7fff, 3'b000}, {32'h0000_8000, 3'b001}, {32'h0007_ffff, 3'b101},
            {32'h0008_0000, 3'b011}, {32'h3fff_ffff, 3'b111}, {32'h4000_1fff, 3'b000},
            {32'h4000_2000, 3'b001}, {32'h4000_8000, 3'b111}, {32'h7fff_d000, 3'b011},
            {32'h7fff_d001, 3'b001}, {32'h7fff_e000, 3'b000}, {32'h8000_0000, 3'b011},
            {32'he001_8000, 3'b011}, {32'he006_0000, 3'b001}, {32'he000_d000, 3'b000},
            {32'he000_c000, 3'b111}, {32'he020_0000, 3'b011}, {32'hffdf_ffff, 3'b111},
            {32'hffe0_0000, 3'b011}, {32'hffff_f000, 3'b000}};
        logic [34:0] prev;
        prev = '0;
        for (int i = 0; i < 20; i++) begin
            u_core.cyc(1'b1, tab[i][34:3], tab[i][2], 1'b0, 1'b0, 1'b0);
            @(negedge clock);
            check(resp_err, tab[i][1]);
            check(fwd_valid, !tab[i][1]);
            check(resp_prefetch_abort, tab[i][1] & tab[i][2]);
            check(resp_data_abort, tab[i][1] & !tab[i][2]);
            check(small_err, tab[i][0]);
            if (prev[1]) begin
                check(last_abort_addr_q, prev[34:3]);
                check(last_abort_fetch_q, prev[2]);
            end
            prev = tab[i];
        end
    endtask
    // Middle variant, data accesses only; row is {addr, aborts}
    task automatic run_mid();
        logic [32:0] mid [8] = '{
            {32'h0000_ffff, 1'b0}, {32'h0001_0000, 1'b1}, {32'h4000_3fff, 1'b0}, {32'h4000_4000, 1'b1},
            {32'h7fff_dfff, 1'b1}, {32'h7fff_e000, 1'b0}, {32'h8000_0000, 1'b0}, {32'he006_0000, 1'b1}};
        for (int i = 0; i < 8; i++) begin
            u_core.cyc(1'b1, mid[i][32:1], 1'b0, 1'b0, 1'b0, 1'b0);
            @(negedge clock);
            check(mid_err, mid[i][0]);
        end
    endtask
    // Fetch with three advances then execute; a flush on the third advance cancels the abort
    task automatic run_pipe(input logic fl, input logic [31:0] a, input logic exp);
        u_core.cyc(1'b1, a, 1'b1, 1'b1, 1'b0, 1'b0);
        u_core.cyc(1'b0, 32'h0, 1'b0, 1'b1, 1'b0, 1'b0);
        u_core.cyc(1'b0, 32'h0, 1'b0, 1'b1, fl, 1'b0);
        u_core.cyc(1'b0, 32'h0, 1'b0, 1'b0, 1'b0, 1'b1);
        u_core.cyc(1'b0, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0);
        @(negedge clock);
        check(prefetch_abort_take, exp);
        u_core.cyc(1'b0, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0);
        @(negedge clock);
        check(prefetch_abort_take, 1'b0);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        run_regions();
        run_mid();
        run_pipe(1'b0, 32'he000_c000, 1'b1);
        run_pipe(1'b1, 32'he000_c000, 1'b0);
        run_pipe(1'b0, 32'h0000_0100, 1'b0);
        tally_and_finish();
    end
    // Watchdog well beyond the roughly 60 cycles the tests need
    initial begin
        repeat (1000) @(posedge clock);
        errors++;
        tally_and_finish();
    end
endmodule
